/* arp_ping_pkg.sv */
// constants, types and register map of the socket-less request unit
package arp_ping_pkg;

  localparam int CLK_MHZ     = 200;
  localparam int TICK_US     = 100;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 8;
  localparam int FLAG_W  = 3;
  localparam int RTR_W   = 16;
  localparam int RCR_W   = 8;
  localparam int IP_W    = 32;
  localparam int HW_W    = 48;
  localparam int WORD_W  = 16;

  localparam logic [ADDR_W-1:0] ADDR_CMD     = 8'h4C;
  localparam logic [ADDR_W-1:0] ADDR_RTR_HI  = 8'h4D;
  localparam logic [ADDR_W-1:0] ADDR_RTR_LO  = 8'h4E;
  localparam logic [ADDR_W-1:0] ADDR_RCR     = 8'h4F;
  localparam logic [ADDR_W-1:0] ADDR_PIP_0   = 8'h50;
  localparam logic [ADDR_W-1:0] ADDR_PIP_3   = 8'h53;
  localparam logic [ADDR_W-1:0] ADDR_PHA_0   = 8'h54;
  localparam logic [ADDR_W-1:0] ADDR_PHA_5   = 8'h59;
  localparam logic [ADDR_W-1:0] ADDR_SEQ_HI  = 8'h5A;
  localparam logic [ADDR_W-1:0] ADDR_SEQ_LO  = 8'h5B;
  localparam logic [ADDR_W-1:0] ADDR_ID_HI   = 8'h5C;
  localparam logic [ADDR_W-1:0] ADDR_ID_LO   = 8'h5D;
  localparam logic [ADDR_W-1:0] ADDR_MASK    = 8'h5E;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS   = 8'h5F;

  localparam int CMD_ECHO_BIT     = 0;
  localparam int CMD_ARP_BIT      = 1;
  localparam int FLAG_ECHO_BIT    = 0;
  localparam int FLAG_ARP_BIT     = 1;
  localparam int FLAG_TIMEOUT_BIT = 2;

  localparam logic [1:0]       CMD_ECHO    = 2'h1;
  localparam logic [1:0]       CMD_ARP     = 2'h2;
  localparam logic [1:0]       CMD_IDLE    = 2'h0;
  localparam logic [RTR_W-1:0] RTR_RESET   = 16'h07D0;
  localparam logic [RCR_W-1:0] RCR_RESET   = 8'h00;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEND,
    ST_WAIT
  } req_state_e;

  // one request packet handed to the transmit path
  typedef struct packed {
    logic              arp;
    logic              echo;
    logic [IP_W-1:0]   peer_ip;
    logic [WORD_W-1:0] seq;
    logic [WORD_W-1:0] id;
  } req_s;

  // reply events seen by the receive path, one-cycle pulses
  typedef struct packed {
    logic            arp;
    logic            echo;
    logic [HW_W-1:0] hw_addr;
  } reply_s;

endpackage : arp_ping_pkg

/* tick_divider.sv */
// divider that makes the 100 us tick enable from the system clock
`timescale 1ns/1ps
module tick_divider #(
  parameter int CYCLES = 20000
) (
  input  wire logic clock,
  input  wire logic reset_n,
  output logic      tick
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          tick_reg;
  logic          tick_next;

  always_comb begin
    tick_next  = 1'b0;
    count_next = count_reg + CW'(1);
    if (count_reg == LAST) begin
      count_next = '0;
      tick_next  = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : tick_divider

/* retry_timer.sv */
// interval timer counted in ticks, restarted on every transmission
`timescale 1ns/1ps
module retry_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             tick,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] interval,
  output logic                  expire
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             run_reg;
  logic             run_next;
  logic             expire_reg;
  logic             expire_next;

  always_comb begin
    count_next  = count_reg;
    run_next    = run_reg;
    expire_next = 1'b0;
    if (start) begin
      count_next = interval;
      run_next   = 1'b1;
    end else if (run_reg && tick) begin
      // zero interval fires on the first tick rather than never
      if (count_reg <= WIDTH'(1)) begin
        run_next    = 1'b0;
        expire_next = 1'b1;
        count_next  = '0;
      end else begin
        count_next = count_reg - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_reg  <= '0;
      run_reg    <= 1'b0;
      expire_reg <= 1'b0;
    end else begin
      count_reg  <= count_next;
      run_reg    <= run_next;
      expire_reg <= expire_next;
    end
  end

  assign expire = expire_reg;

endmodule : retry_timer

/* socketless_requester.sv */
// socket-less arp / echo request unit with register port and interrupt
`timescale 1ns/1ps
module socketless_requester
  import arp_ping_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  input  wire reply_s            reply,
  input  wire logic              pend_timer_zero,
  output logic                   req_valid,
  output req_s                   req,
  output logic                   irq_out_low
);

  // byte slot of an address inside a multi-byte register, msb first
  function automatic logic [2:0] slot(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] d;
    d = a - base;
    return d[2:0];
  endfunction : slot

  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  logic [1:0]        cmd_reg,   cmd_next;
  logic [RTR_W-1:0]  rtr_reg,   rtr_next;
  logic [RCR_W-1:0]  rcr_reg,   rcr_next;
  logic [IP_W-1:0]   pip_reg,   pip_next;
  logic [HW_W-1:0]   pha_reg,   pha_next;
  logic [WORD_W-1:0] seq_reg,   seq_next;
  logic [WORD_W-1:0] id_reg,    id_next;
  logic [FLAG_W-1:0] mask_reg,  mask_next;
  logic [FLAG_W-1:0] flags_reg, flags_next;

  req_state_e        state_reg, state_next;
  logic [RCR_W-1:0]  retx_reg,  retx_next;
  logic              req_valid_reg, req_valid_next;
  req_s              req_reg,   req_next;
  logic              irq_low_reg, irq_low_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  logic              tick;
  logic              expire;
  logic              timer_start;
  logic [FLAG_W-1:0] flag_set;
  logic              done;
  logic              capture_hw;
  logic              hit;

  tick_divider #(
    .CYCLES (TICK_CYCLES_P)
  ) u_tick (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (tick)
  );

  retry_timer #(
    .WIDTH (RTR_W)
  ) u_timer (
    .clock    (clock),
    .reset_n  (reset_n),
    .tick     (tick),
    .start    (timer_start),
    .interval (rtr_reg),
    .expire   (expire)
  );

  // request sequencer
  always_comb begin
    state_next     = state_reg;
    retx_next      = retx_reg;
    req_valid_next = 1'b0;
    req_next       = req_reg;
    timer_start    = 1'b0;
    flag_set       = '0;
    done           = 1'b0;
    capture_hw     = 1'b0;
    hit            = (cmd_reg[CMD_ARP_BIT] && reply.arp) ||
                     (cmd_reg[CMD_ECHO_BIT] && reply.echo);
    if (state_reg != ST_IDLE && hit) begin
      flag_set[FLAG_ARP_BIT]  = cmd_reg[CMD_ARP_BIT];
      flag_set[FLAG_ECHO_BIT] = cmd_reg[CMD_ECHO_BIT];
      capture_hw = cmd_reg[CMD_ARP_BIT];
      done       = 1'b1;
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cmd_reg != CMD_IDLE) begin
            retx_next  = '0;
            state_next = ST_SEND;
          end
        end
        ST_SEND: begin
          req_valid_next = 1'b1;
          req_next.arp   = cmd_reg[CMD_ARP_BIT];
          req_next.echo  = cmd_reg[CMD_ECHO_BIT];
          req_next.peer_ip = pip_reg;
          req_next.seq = seq_reg;
          req_next.id  = id_reg;
          timer_start  = 1'b1;
          state_next   = ST_WAIT;
        end
        ST_WAIT: begin
          if (expire) begin
            if (retx_reg == rcr_reg) begin
              flag_set[FLAG_TIMEOUT_BIT] = 1'b1;
              done       = 1'b1;
              state_next = ST_IDLE;
            end else begin
              retx_next  = retx_reg + RCR_W'(1);
              state_next = ST_SEND;
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg     <= ST_IDLE;
      retx_reg      <= '0;
      req_valid_reg <= 1'b0;
      req_reg       <= '0;
    end else begin
      state_reg     <= state_next;
      retx_reg      <= retx_next;
      req_valid_reg <= req_valid_next;
      req_reg       <= req_next;
    end
  end

  // register file
  always_comb begin
    cmd_next   = cmd_reg;
    rtr_next   = rtr_reg;
    rcr_next   = rcr_reg;
    pip_next   = pip_reg;
    pha_next   = pha_reg;
    seq_next   = seq_reg;
    id_next    = id_reg;
    mask_next  = mask_reg;
    flags_next = flags_reg;
    if (wr_en) begin
      if (addr == ADDR_CMD) begin
        // launch only from idle and with one bit; others are dropped
        if (cmd_reg == CMD_IDLE &&
            (wdata[1:0] == CMD_ARP || wdata[1:0] == CMD_ECHO)) begin
          cmd_next = wdata[1:0];
        end
      end else if (addr == ADDR_RTR_HI) begin
        rtr_next[RTR_W-1 -: DATA_W] = wdata;
      end else if (addr == ADDR_RTR_LO) begin
        rtr_next[DATA_W-1:0] = wdata;
      end else if (addr == ADDR_RCR) begin
        rcr_next = wdata;
      end else if (in_range(addr, ADDR_PIP_0, ADDR_PIP_3)) begin
        pip_next[IP_W-DATA_W*(32'(slot(addr, ADDR_PIP_0))+1) +: DATA_W]
          = wdata;
      end else if (addr == ADDR_SEQ_HI) begin
        seq_next[WORD_W-1 -: DATA_W] = wdata;
      end else if (addr == ADDR_SEQ_LO) begin
        seq_next[DATA_W-1:0] = wdata;
      end else if (addr == ADDR_ID_HI) begin
        id_next[WORD_W-1 -: DATA_W] = wdata;
      end else if (addr == ADDR_ID_LO) begin
        id_next[DATA_W-1:0] = wdata;
      end else if (addr == ADDR_MASK) begin
        mask_next = wdata[FLAG_W-1:0];
      end else if (addr == ADDR_FLAGS) begin
        flags_next = flags_reg & ~wdata[FLAG_W-1:0];
      end
    end
    // set wins over a clear in the same cycle
    flags_next = flags_next | flag_set;
    if (done) begin
      cmd_next = CMD_IDLE;
    end
    if (capture_hw) begin
      pha_next = reply.hw_addr;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cmd_reg   <= CMD_IDLE;
      rtr_reg   <= RTR_RESET;
      rcr_reg   <= RCR_RESET;
      pip_reg   <= '0;
      pha_reg   <= '0;
      seq_reg   <= '0;
      id_reg    <= '0;
      mask_reg  <= FLAG_RESET;
      flags_reg <= FLAG_RESET;
    end else begin
      cmd_reg   <= cmd_next;
      rtr_reg   <= rtr_next;
      rcr_reg   <= rcr_next;
      pip_reg   <= pip_next;
      pha_reg   <= pha_next;
      seq_reg   <= seq_next;
      id_reg    <= id_next;
      mask_reg  <= mask_next;
      flags_reg <= flags_next;
    end
  end

  // read port, data only in the cycle after the strobe
  always_comb begin
    rdata_next = '0;
    if (rd_en) begin
      if (addr == ADDR_CMD) begin
        rdata_next = {{(DATA_W-2){1'b0}}, cmd_reg};
      end else if (addr == ADDR_RTR_HI) begin
        rdata_next = rtr_reg[RTR_W-1 -: DATA_W];
      end else if (addr == ADDR_RTR_LO) begin
        rdata_next = rtr_reg[DATA_W-1:0];
      end else if (addr == ADDR_RCR) begin
        rdata_next = rcr_reg;
      end else if (in_range(addr, ADDR_PIP_0, ADDR_PIP_3)) begin
        rdata_next =
          pip_reg[IP_W-DATA_W*(32'(slot(addr, ADDR_PIP_0))+1) +: DATA_W];
      end else if (in_range(addr, ADDR_PHA_0, ADDR_PHA_5)) begin
        rdata_next =
          pha_reg[HW_W-DATA_W*(32'(slot(addr, ADDR_PHA_0))+1) +: DATA_W];
      end else if (addr == ADDR_SEQ_HI) begin
        rdata_next = seq_reg[WORD_W-1 -: DATA_W];
      end else if (addr == ADDR_SEQ_LO) begin
        rdata_next = seq_reg[DATA_W-1:0];
      end else if (addr == ADDR_ID_HI) begin
        rdata_next = id_reg[WORD_W-1 -: DATA_W];
      end else if (addr == ADDR_ID_LO) begin
        rdata_next = id_reg[DATA_W-1:0];
      end else if (addr == ADDR_MASK) begin
        rdata_next = {{(DATA_W-FLAG_W){1'b0}}, mask_reg};
      end else if (addr == ADDR_FLAGS) begin
        rdata_next = {{(DATA_W-FLAG_W){1'b0}}, flags_reg};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // interrupt pin; once low it waits only for flag or mask to drop
  always_comb begin
    irq_low_next = irq_low_reg;
    if (!(|(flags_reg & mask_reg))) begin
      irq_low_next = 1'b1;
    end else if (pend_timer_zero) begin
      // assert with pending timer at zero
      irq_low_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_low_reg <= 1'b1;
    end else begin
      irq_low_reg <= irq_low_next;
    end
  end

  assign rdata       = rdata_reg;
  assign req_valid   = req_valid_reg;
  assign req         = req_reg;
  assign irq_out_low = irq_low_reg;

endmodule : socketless_requester

/* socketless_requester_properties.sv */
// port-level checker for the socket-less request unit
`timescale 1ns/1ps
module socketless_requester_properties
  import arp_ping_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic              clock,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] rdata,
  input wire reply_s            reply,
  input wire logic              pend_timer_zero,
  input wire logic              req_valid,
  input wire req_s              req,
  input wire logic              irq_out_low
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_rdata_only_after: assert property (
    !$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_cmd_reserved: assert property (
    rd_en && addr == ADDR_CMD |=> rdata[7:2] == 6'h00)
    else $error("command reserved bits set");
  a_flag_reserved: assert property (
    rd_en && addr == ADDR_FLAGS |=> rdata[7:3] == 5'h00)
    else $error("flag reserved bits set");
  a_unmapped_zero: assert property (
    rd_en && addr > ADDR_FLAGS |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_req_one_kind: assert property (
    req_valid |-> req.arp != req.echo)
    else $error("request of both or no kind");
  // a zero interval can expire on the very next tick, two idle cycles
  a_req_spacing: assert property (
    req_valid |=> !req_valid [*2])
    else $error("requests too close");
  a_req_holds: assert property (
    !req_valid |-> $stable(req))
    else $error("request fields moved");
  a_irq_gated: assert property (
    irq_out_low && !pend_timer_zero |=> irq_out_low)
    else $error("interrupt while pending timer busy");
  a_mask_release: assert property (
    wr_en && addr == ADDR_MASK && wdata == 8'h00 |-> ##2 irq_out_low)
    else $error("interrupt kept after mask cleared");
endmodule : socketless_requester_properties

bind socketless_requester socketless_requester_properties #(
  .TICK_CYCLES_P(TICK_CYCLES_P)
) u_props (.clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .reply(reply),
  .pend_timer_zero(pend_timer_zero), .req_valid(req_valid), .req(req),
  .irq_out_low(irq_out_low));

/* remote_node_model.sv */
// remote node model: answers arp and echo requests after a delay
`timescale 1ns/1ps
module remote_node_model
  import arp_ping_pkg::*;
#(
  parameter logic [HW_W-1:0] HW = 48'h0A1B2C3D4E5F
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       answer,
  input  wire logic [7:0] delay,
  input  wire logic       req_valid,
  input  wire req_s       req,
  output reply_s          reply,
  output logic [7:0]      packets
);
  logic [7:0] wait_reg;
  logic       busy_reg;
  logic       kind_reg;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      {reply, packets, wait_reg, busy_reg, kind_reg} <= '0;
    end else begin
      reply.arp     <= 1'b0;
      reply.echo    <= 1'b0;
      // address toggles outside a reply so a value taken one cycle after a reply never matches
      reply.hw_addr <= ~reply.hw_addr;
      if (req_valid) begin
        packets  <= packets + 8'h01;
        busy_reg <= answer;
        kind_reg <= req.arp;
        wait_reg <= delay;
      end else if (busy_reg && wait_reg != 8'h00) begin
        wait_reg <= wait_reg - 8'h01;
      end else if (busy_reg) begin
        busy_reg      <= 1'b0;
        reply.arp     <= kind_reg;
        reply.echo    <= !kind_reg;
        reply.hw_addr <= HW;
      end
    end
  end
endmodule : remote_node_model

/* socketless_arp_ping_requester_bench.sv */
// self-checking bench of the socket-less request unit
`timescale 1ns/1ps
module socketless_arp_ping_requester_bench;
  import arp_ping_pkg::*;
  localparam int TK = 10;
  localparam logic [47:0] HW = 48'h0A1B2C3D4E5F;
  logic              clock = 0, reset_n = 0, wr_en = 0, rd_en = 0;
  logic              pend_timer_zero = 1, answer = 0, kind, req_valid;
  logic              irq_out_low;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 8'h00, d, rdata;
  logic [7:0]        delay = 8'h04, packets, base;
  logic [31:0]       seed = 32'h48BA, ip;
  logic [15:0]       seq, id;
  reply_s            reply;
  req_s              req;
  int                num_errors = 0, n_compared = 0;

  always #2.5 clock = ~clock;

  socketless_requester #(.TICK_CYCLES_P(TK)) u_socketless_requester (
    .clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .reply(reply),
    .pend_timer_zero(pend_timer_zero), .req_valid(req_valid), .req(req),
    .irq_out_low(irq_out_low));
  remote_node_model #(.HW(HW)) u_remote_node_model (
    .clock(clock), .reset_n(reset_n), .answer(answer), .delay(delay),
    .req_valid(req_valid), .req(req), .reply(reply), .packets(packets));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // flag raised by a finished request: reply kind or timeout
  function automatic logic [7:0] exp_flag(input logic arp, input logic ans);
    return ans ? (arp ? 8'h02 : 8'h01) : 8'h04;
  endfunction : exp_flag

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // the gap cycle keeps strobes from being assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 v = rdata;
    @(posedge clock);
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(v, exp);
  endtask : rc

  task automatic wait_idle;
    int n;
    d = 8'hFF;
    n = 0;
    while (d !== 8'h00 && n < 200) begin
      rd(ADDR_CMD, d);
      n++;
    end
    check(d, 8'h00);
  endtask : wait_idle

  task automatic launch(input logic arp);
    base = packets;
    wr(ADDR_CMD, arp ? {6'h00, CMD_ARP} : {6'h00, CMD_ECHO});
    wait_idle();
  endtask : launch

  initial begin
    #50000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rc(ADDR_CMD, 8'h00);
    rc(ADDR_RTR_HI, 8'h07);
    rc(ADDR_RTR_LO, 8'hD0);
    rc(ADDR_RCR, 8'h00);
    rc(ADDR_MASK, 8'h00);
    rc(ADDR_FLAGS, 8'h00);
    rc(8'h60, 8'h00);
    seed = xs(seed);
    ip   = seed;
    seed = xs(seed);
    {seq, id} = seed;
    for (int i = 0; i < 4; i++) wr(8'(ADDR_PIP_0 + i), ip[31-8*i -: 8]);
    wr(ADDR_SEQ_HI, seq[15:8]);
    wr(ADDR_SEQ_LO, seq[7:0]);
    wr(ADDR_ID_HI, id[15:8]);
    wr(ADDR_ID_LO, id[7:0]);
    wr(ADDR_RTR_HI, 8'h00);
    wr(ADDR_RTR_LO, 8'h03);
    wr(ADDR_RCR, 8'h02);
    wr(ADDR_MASK, 8'h07);
    rc(8'(ADDR_PIP_0 + 2), ip[15:8]);
    rc(ADDR_SEQ_HI, seq[15:8]);
    wr(ADDR_PHA_0, 8'hFF);
    rc(ADDR_PHA_0, 8'h00);
    wr(ADDR_CMD, 8'h03);
    rc(ADDR_CMD, 8'h00);
    answer <= 1'b1;
    launch(1'b1);
    check({req.arp, req.echo}, 2'h2);
    check(req.peer_ip, ip);
    rc(ADDR_FLAGS, 8'h02);
    check(irq_out_low, 1'b0);
    for (int i = 0; i < 6; i++) rc(8'(ADDR_PHA_0 + i), HW[47-8*i -: 8]);
    wr(ADDR_FLAGS, 8'h00);
    rc(ADDR_FLAGS, 8'h02);
    wr(ADDR_FLAGS, 8'h02);
    rc(ADDR_FLAGS, 8'h00);
    check(irq_out_low, 1'b1);
    answer          <= 1'b0;
    pend_timer_zero <= 1'b0;
    launch(1'b0);
    check(packets - base, 8'h03);
    check({req.seq, req.id}, {seq, id});
    rc(ADDR_FLAGS, 8'h04);
    check(irq_out_low, 1'b1);
    pend_timer_zero <= 1'b1;
    repeat (2) @(posedge clock);
    check(irq_out_low, 1'b0);
    wr(ADDR_MASK, 8'h00);
    // the pin rises on the edge that ends the write task; look one later
    @(posedge clock);
    check(irq_out_low, 1'b1);
    wr(ADDR_FLAGS, 8'h04);
    wr(ADDR_MASK, 8'h01);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      kind = seed[0];
      answer <= seed[1];
      delay  <= {4'h0, seed[7:4]};
      @(posedge clock);
      launch(kind);
      check(packets - base, answer ? 8'h01 : 8'h03);
      rc(ADDR_FLAGS, exp_flag(kind, answer));
      check(irq_out_low, !(answer && !kind));
      wr(ADDR_FLAGS, 8'h07);
    end
    report_and_stop();
  end
endmodule : socketless_arp_ping_requester_bench
